// >>> verilog/sesr_pkg.sv
// Constants and types shared by the switch event status register bank
package sesr_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] SESR_OFF_STATUS = 8'h01;
	localparam logic [7:0] SESR_OFF_RSVD_A = 8'h04;
	localparam logic [7:0] SESR_OFF_RSVD_B = 8'h05;
	localparam logic [7:0] SESR_OFF_RSVD_C = 8'h06;
	localparam logic [7:0] SESR_OFF_EVENT = 8'h07;

	// Event capture field positions
	localparam int SESR_NUM_PORTS = 4;
	localparam int SESR_FLAG_W = 6;
	localparam int SESR_EVT_PWR_LSB = 0;
	localparam int SESR_EVT_CLK_BIT = 4;
	localparam int SESR_EVT_SEL_BIT = 5;

	// Primary status field positions
	localparam int SESR_STAT_PWR_LSB = 0;
	localparam int SESR_STAT_CLK_BIT = 4;
	localparam int SESR_STAT_SEL_LSB = 5;

	// Reset values, fixed read values and device address
	localparam logic [5:0] SESR_FLAGS_RST = 6'h00;
	localparam logic [7:0] SESR_RSVD_VALUE = 8'h00;
	localparam logic [7:0] SESR_UNMAPPED_VALUE = 8'h00;
	localparam logic [7:0] SESR_PTR_RST = 8'h00;
	localparam logic [6:0] SESR_DEV_ADDR = 7'h2C;

	// Serial protocol counts
	localparam logic [3:0] SESR_BITS_PER_BYTE = 4'h8;

	typedef enum logic [3:0] {
		SESR_IDLE,
		SESR_ADDR,
		SESR_ADDR_ACK,
		SESR_REG,
		SESR_REG_ACK,
		SESR_WDATA,
		SESR_WDATA_ACK,
		SESR_RDATA,
		SESR_RACK
	} sesr_state_t;

endpackage

// >>> verilog/sesr_event_capture.sv
// Sticky change flags and interrupt request of the event capture register
`timescale 1ns/1ps
`default_nettype none

module sesr_event_capture (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [1:0] selPort,
	input wire logic [3:0] clkDetect,
	input wire logic [3:0] sourcePowerSense,
	input wire logic clearReq,
	output logic [5:0] flags_r,
	output logic irq_r
);

	logic [5:0] flagsNxt;
	logic irqNxt;
	logic [1:0] selPrev_r;
	logic [1:0] selPrevNxt;
	logic selClkPrev_r;
	logic selClkPrevNxt;
	logic [3:0] pwrPrev_r;
	logic [3:0] pwrPrevNxt;
	logic primed_r;
	logic primedNxt;
	logic [5:0] events;
	logic selClk;

	assign selClk = clkDetect[selPort];

	always_comb begin
		events = '0;
		events[sesr_pkg::SESR_EVT_SEL_BIT] = primed_r && (selPort != selPrev_r);
		events[sesr_pkg::SESR_EVT_CLK_BIT] = primed_r && (selPort == selPrev_r)
			&& (selClk != selClkPrev_r);
		events[sesr_pkg::SESR_EVT_PWR_LSB +: sesr_pkg::SESR_NUM_PORTS] =
			primed_r ? (sourcePowerSense ^ pwrPrev_r) : 4'h0;
		// Keep accumulating events
		// A change arriving with the clear is kept: set wins
		flagsNxt = (clearReq ? sesr_pkg::SESR_FLAGS_RST : flags_r) | events;
		irqNxt = |flagsNxt;
		selPrevNxt = selPort;
		selClkPrevNxt = selClk;
		pwrPrevNxt = sourcePowerSense;
		// First cycle after reset only samples, so static levels raise nothing
		primedNxt = 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= sesr_pkg::SESR_FLAGS_RST;
			irq_r <= 1'b0;
			selPrev_r <= 2'h0;
			selClkPrev_r <= 1'b0;
			pwrPrev_r <= 4'h0;
			primed_r <= 1'b0;
		end else begin
			flags_r <= flagsNxt;
			irq_r <= irqNxt;
			selPrev_r <= selPrevNxt;
			selClkPrev_r <= selClkPrevNxt;
			pwrPrev_r <= pwrPrevNxt;
			primed_r <= primedNxt;
		end
	end

endmodule

`default_nettype wire

// >>> verilog/sesr_status_regs.sv
// Serial slave register port with status, reserved and event capture registers
// Operation
// - Offsets reserved_reg_a to reserved_reg_c are read-only bytes of unspecified content.
// - Event capture register at event_capture is read-only; writes leave it unchanged.
// - Bit 5 sets when the selected port changes since last status read.
// - Bit 4 sets when the selected port's clock detect changes while the port selection holds.
// - Bits 3 to 0 flag source power changes on ports 4 to 1.
// - Every change flag reads 0 unless a change occurred since the status read.
// - Event flags set on each change; the interrupt request is high while any flag is set.
// - Reading status at 0x01 clears the interrupt and the event register.
// - Until status is read, further events keep accumulating in the register.
`timescale 1ns/1ps
`default_nettype none

module sesr_status_regs #(
	parameter logic [6:0] DEV_ADDR = sesr_pkg::SESR_DEV_ADDR
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [1:0] selPort,
	input wire logic [3:0] clkDetect,
	input wire logic [3:0] sourcePowerSense,
	output logic irq
);

	// Pin synchronisers: first stage feeds only the second
	logic [1:0] pinSyncA_r;
	logic [1:0] pinSyncB_r;
	logic [7:0] evtSyncA_r;
	logic [7:0] evtSyncB_r;
	logic sclD_r;
	logic sdaD_r;
	logic sclS;
	logic sdaS;
	logic [3:0] clkDetS;
	logic [3:0] pwrS;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;

	assign sclS = pinSyncB_r[1];
	assign sdaS = pinSyncB_r[0];
	assign clkDetS = evtSyncB_r[7:4];
	assign pwrS = evtSyncB_r[3:0];
	assign sclRise = sclS && !sclD_r;
	assign sclFall = !sclS && sclD_r;
	assign startSeen = sclS && sclD_r && sdaD_r && !sdaS;
	assign stopSeen = sclS && sclD_r && !sdaD_r && sdaS;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinSyncA_r <= 2'h3;
			pinSyncB_r <= 2'h3;
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
		end else begin
			pinSyncA_r <= {sclIn, sdaIn};
			pinSyncB_r <= pinSyncA_r;
			sclD_r <= pinSyncB_r[1];
			sdaD_r <= pinSyncB_r[0];
		end
	end

	// Event levels have no idle value: a reset value would fake a change on release.
	// These stages fill from the pins while reset is held, so the clock must run then.
	always_ff @(posedge sys_clk) begin
		evtSyncA_r <= {clkDetect, sourcePowerSense};
		evtSyncB_r <= evtSyncA_r;
	end

	logic [5:0] flags;
	logic clearReq;

	sesr_event_capture u_capture (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.selPort(selPort),
		.clkDetect(clkDetS),
		.sourcePowerSense(pwrS),
		.clearReq(clearReq),
		.flags_r(flags),
		.irq_r(irq)
	);

	logic [7:0] ptr_r;
	logic [7:0] ptrNxt;

	// Read data for the current pointer
	logic [7:0] readByte;

	always_comb begin
		case (ptr_r)
			sesr_pkg::SESR_OFF_STATUS: begin
				readByte = {1'b0, selPort, clkDetS[selPort], pwrS};
			end
			sesr_pkg::SESR_OFF_RSVD_A, sesr_pkg::SESR_OFF_RSVD_B,
			sesr_pkg::SESR_OFF_RSVD_C: begin
				readByte = sesr_pkg::SESR_RSVD_VALUE;
			end
			sesr_pkg::SESR_OFF_EVENT: begin
				readByte = {2'b00, flags};
			end
			default: begin
				readByte = sesr_pkg::SESR_UNMAPPED_VALUE;
			end
		endcase
	end

	// Serial slave state
	sesr_pkg::sesr_state_t state_r;
	sesr_pkg::sesr_state_t stateNxt;
	logic [3:0] bitCnt_r;
	logic [3:0] bitCntNxt;
	logic [7:0] shift_r;
	logic [7:0] shiftNxt;
	logic [7:0] tx_r;
	logic [7:0] txNxt;
	logic rw_r;
	logic rwNxt;
	logic nack_r;
	logic nackNxt;
	logic sdaOe_r;
	logic sdaOeNxt;
	logic sdaOut_r;

	assign sdaOe = sdaOe_r;
	assign sdaOut = sdaOut_r;

	always_comb begin
		stateNxt = state_r;
		bitCntNxt = bitCnt_r;
		shiftNxt = shift_r;
		txNxt = tx_r;
		ptrNxt = ptr_r;
		rwNxt = rw_r;
		nackNxt = nack_r;
		sdaOeNxt = sdaOe_r;
		clearReq = 1'b0;
		if (startSeen) begin
			stateNxt = sesr_pkg::SESR_ADDR;
			bitCntNxt = 4'h0;
			sdaOeNxt = 1'b0;
		end else if (stopSeen) begin
			stateNxt = sesr_pkg::SESR_IDLE;
			sdaOeNxt = 1'b0;
		end else if (sclRise) begin
			case (state_r)
				sesr_pkg::SESR_ADDR, sesr_pkg::SESR_REG, sesr_pkg::SESR_WDATA: begin
					shiftNxt = {shift_r[6:0], sdaS};
					bitCntNxt = bitCnt_r + 4'h1;
				end
				sesr_pkg::SESR_RDATA: begin
					bitCntNxt = bitCnt_r + 4'h1;
				end
				sesr_pkg::SESR_RACK: begin
					nackNxt = sdaS;
				end
				default: begin
				end
			endcase
		end else if (sclFall) begin
			case (state_r)
				sesr_pkg::SESR_ADDR: begin
					if (bitCnt_r == sesr_pkg::SESR_BITS_PER_BYTE) begin
						if (shift_r[7:1] == DEV_ADDR) begin
							rwNxt = shift_r[0];
							sdaOeNxt = 1'b1;
							stateNxt = sesr_pkg::SESR_ADDR_ACK;
						end else begin
							stateNxt = sesr_pkg::SESR_IDLE;
						end
					end
				end
				sesr_pkg::SESR_ADDR_ACK, sesr_pkg::SESR_RACK: begin
					bitCntNxt = 4'h0;
					if (state_r == sesr_pkg::SESR_RACK && nack_r) begin
						sdaOeNxt = 1'b0;
						stateNxt = sesr_pkg::SESR_IDLE;
					end else if (state_r == sesr_pkg::SESR_RACK || rw_r) begin
						txNxt = readByte;
						sdaOeNxt = !readByte[7];
						clearReq = (ptr_r == sesr_pkg::SESR_OFF_STATUS);
						stateNxt = sesr_pkg::SESR_RDATA;
					end else begin
						sdaOeNxt = 1'b0;
						stateNxt = sesr_pkg::SESR_REG;
					end
				end
				sesr_pkg::SESR_REG: begin
					if (bitCnt_r == sesr_pkg::SESR_BITS_PER_BYTE) begin
						ptrNxt = shift_r;
						sdaOeNxt = 1'b1;
						stateNxt = sesr_pkg::SESR_REG_ACK;
					end
				end
				sesr_pkg::SESR_REG_ACK, sesr_pkg::SESR_WDATA_ACK: begin
					sdaOeNxt = 1'b0;
					bitCntNxt = 4'h0;
					stateNxt = sesr_pkg::SESR_WDATA;
				end
				sesr_pkg::SESR_WDATA: begin
					if (bitCnt_r == sesr_pkg::SESR_BITS_PER_BYTE) begin
						ptrNxt = ptr_r + 8'h01;
						sdaOeNxt = 1'b1;
						stateNxt = sesr_pkg::SESR_WDATA_ACK;
					end
				end
				sesr_pkg::SESR_RDATA: begin
					if (bitCnt_r == sesr_pkg::SESR_BITS_PER_BYTE) begin
						ptrNxt = ptr_r + 8'h01;
						sdaOeNxt = 1'b0;
						nackNxt = 1'b0;
						stateNxt = sesr_pkg::SESR_RACK;
					end else begin
						txNxt = {tx_r[6:0], 1'b0};
						sdaOeNxt = !tx_r[6];
					end
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= sesr_pkg::SESR_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			tx_r <= 8'h00;
			ptr_r <= sesr_pkg::SESR_PTR_RST;
			rw_r <= 1'b0;
			nack_r <= 1'b0;
			sdaOe_r <= 1'b0;
			sdaOut_r <= 1'b0;
		end else begin
			state_r <= stateNxt;
			bitCnt_r <= bitCntNxt;
			shift_r <= shiftNxt;
			tx_r <= txNxt;
			ptr_r <= ptrNxt;
			rw_r <= rwNxt;
			nack_r <= nackNxt;
			sdaOe_r <= sdaOeNxt;
			// Open drain: only ever pulls low
			sdaOut_r <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> dv/sesr_status_regs_monitor.sv
// Port-level checks of the event status register bank
`timescale 1ns/1ps
`default_nettype none

module sesr_status_regs_monitor (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [1:0] selPort,
	input wire logic [3:0] clkDetect,
	input wire logic [3:0] sourcePowerSense,
	input wire logic irq
);
	logic [3:0] quietCnt_r;
	wire logic clkSel = clkDetect[selPort];

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Cycles since any event input moved; saturates so idle time never wraps
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			quietCnt_r <= 4'hF;
		else if ($changed({selPort, clkDetect, sourcePowerSense}))
			quietCnt_r <= 4'h0;
		else if (quietCnt_r != 4'hF)
			quietCnt_r <= quietCnt_r + 4'h1;
	end

	property p_pwrEvt;
		$changed(sourcePowerSense) |-> ##[1:5] irq;
	endproperty
	a_pwrEvt: assert property (p_pwrEvt) else $error("power change gave no irq");
	property p_selEvt;
		$changed(selPort) |-> ##[1:3] irq;
	endproperty
	a_selEvt: assert property (p_selEvt) else $error("port change gave no irq");
	property p_clkEvt;
		$changed(clkSel) && $stable(selPort) |-> ##[1:5] irq;
	endproperty
	a_clkEvt: assert property (p_clkEvt) else $error("clock detect gave no irq");
	property p_noSpurious;
		$rose(irq) |-> quietCnt_r < 4'h8;
	endproperty
	a_noSpurious: assert property (p_noSpurious) else $error("irq rose without event");
	property p_resetClear;
		$rose(rst_n) |-> !irq;
	endproperty
	a_resetClear: assert property (p_resetClear) else $error("irq set out of reset");
	property p_clrOnRead;
		$fell(irq) |-> ##[0:3] sdaOe;
	endproperty
	a_clrOnRead: assert property (p_clrOnRead) else $error("irq fell outside read");
	property p_holdIrq;
		$fell(irq) |-> !sclIn;
	endproperty
	a_holdIrq: assert property (p_holdIrq) else $error("irq fell with clock high");
	property p_drvLow;
		$changed(sdaOe) |-> !sclIn;
	endproperty
	a_drvLow: assert property (p_drvLow) else $error("data moved with clock high");
	property p_openDrain;
		sdaOe |-> !sdaOut;
	endproperty
	a_openDrain: assert property (p_openDrain) else $error("data line driven high");
endmodule

bind sesr_status_regs sesr_status_regs_monitor u_mon (
	.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
	.sdaOe(sdaOe), .selPort(selPort), .clkDetect(clkDetect),
	.sourcePowerSense(sourcePowerSense), .irq(irq)
);
`default_nettype wire

// >>> dv/sesr_host_model.sv
// Serial bus master standing in for the sink controller
`timescale 1ns/1ps
`default_nettype none

module sesr_host_model #(
	parameter logic [6:0] ADDR = 7'h2C
) (
	input wire logic sys_clk,
	input wire logic sdaOe,
	input wire logic sdaOut,
	output logic sclIn,
	output logic sdaIn
);
	logic mSda;

	// Open-drain data line with pull-up
	assign sdaIn = mSda & (sdaOe ? sdaOut : 1'b1);

	initial begin
		sclIn = 1'b1;
		mSda = 1'b1;
	end

	task automatic hp;
		repeat (5) @(posedge sys_clk);
	endtask

	// Data moves a half phase after the clock falls, so it never races the fall
	task automatic sb(input logic b, output logic r);
		hp;
		mSda <= b;
		hp;
		sclIn <= 1'b1;
		hp;
		r = sdaIn;
		sclIn <= 1'b0;
	endtask

	task automatic st;
		hp;
		mSda <= 1'b1;
		hp;
		sclIn <= 1'b1;
		hp;
		mSda <= 1'b0;
		hp;
		sclIn <= 1'b0;
	endtask

	task automatic sp;
		hp;
		mSda <= 1'b0;
		hp;
		sclIn <= 1'b1;
		hp;
		mSda <= 1'b1;
		hp;
	endtask

	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			sb(d[i], r);
		sb(1'b1, r);
		ack = ~r;
	endtask

	task automatic rd(input logic [7:0] off, output logic [7:0] d, output logic ok);
		logic a, b, c, r;
		st;
		wb({ADDR, 1'b0}, a);
		wb(off, b);
		st;
		wb({ADDR, 1'b1}, c);
		for (int i = 7; i >= 0; i--)
			sb(1'b1, d[i]);
		sb(1'b1, r);
		sp;
		ok = a & b & c;
	endtask

	task automatic wr(input logic [7:0] off, input logic [7:0] v, output logic ok);
		logic a, b, c;
		st;
		wb({ADDR, 1'b0}, a);
		wb(off, b);
		wb(v, c);
		sp;
		ok = a & b & c;
	endtask
endmodule
`default_nettype wire

// >>> dv/sesr_status_regs_tb.sv
// Self-checking bench for the event status register bank
`timescale 1ns/1ps
`default_nettype none

module sesr_status_regs_tb;
	logic sys_clk;
	logic rst_n;
	logic [1:0] selPort;
	logic [3:0] clkDetect;
	logic [3:0] sourcePowerSense;
	wire logic sclIn;
	wire logic sdaIn;
	wire logic sdaOe;
	wire logic sdaOut;
	wire logic irq;
	logic [7:0] rv;
	logic ok;
	int errorCnt;
	int numChecks;
	int cyc;

	sesr_status_regs u_dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .selPort(selPort), .clkDetect(clkDetect),
		.sourcePowerSense(sourcePowerSense), .irq(irq)
	);

	sesr_host_model #(.ADDR(sesr_pkg::SESR_DEV_ADDR)) u_host (
		.sys_clk(sys_clk), .sdaOe(sdaOe), .sdaOut(sdaOut), .sclIn(sclIn), .sdaIn(sdaIn)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic testDone;
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// A whole read lasts about 600 cycles; the ceiling leaves ample margin
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errorCnt++;
			testDone;
		end
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		numChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rdChk(input logic [7:0] off, input logic [7:0] exp);
		u_host.rd(off, rv, ok);
		chk({7'h00, ok}, 8'h01);
		chk(rv, exp);
	endtask

	task automatic wt;
		repeat (10) @(posedge sys_clk);
	endtask

	initial begin
		rst_n = 1'b0;
		selPort = 2'h0;
		clkDetect = 4'h0;
		sourcePowerSense = 4'h0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		wt;
		rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h00);
		for (int i = 4; i < 7; i++)
			rdChk(8'(i), sesr_pkg::SESR_RSVD_VALUE);
		for (int i = 0; i < 4; i++) begin
			sourcePowerSense[i] <= 1'b1;
			wt;
			chk({7'h00, irq}, 8'h01);
			rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h01 << i);
			rdChk(sesr_pkg::SESR_OFF_STATUS, {4'h0, sourcePowerSense});
			rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h00);
			chk({7'h00, irq}, 8'h00);
		end
		// Clock detect of an unselected port must stay silent
		clkDetect[1] <= 1'b1;
		wt;
		chk({7'h00, irq}, 8'h00);
		// Port change alone, with the request low beforehand
		selPort <= 2'h2;
		wt;
		rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h20);
		sourcePowerSense[0] <= 1'b0;
		wt;
		clkDetect[2] <= 1'b1;
		wt;
		rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h31);
		u_host.wr(sesr_pkg::SESR_OFF_EVENT, 8'hFF, ok);
		chk({7'h00, ok}, 8'h01);
		rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h31);
		rdChk(sesr_pkg::SESR_OFF_STATUS, 8'h5E);
		rdChk(sesr_pkg::SESR_OFF_EVENT, 8'h00);
		testDone;
	end
endmodule
`default_nettype wire
